// *** hdl/dtsp_port.sv ***
// Debug trace serial port: serial debug channel and real-time trace outputs
// Overview of operation
// - Sync serial input, take bit on clock high
// - Serial output registered, changes after clock high
// - Four-bit captured data bus output
// - Strobe clock rises mid valid status window
// - Quiet bit freezes trace once strobe runs, keeps triggers
// - Strobe idle until first C, D, F
// - Core status synchronous, unrelated to bus
// - All-ones output is AND of status
`timescale 1ns/10ps
`default_nettype none
module dtsp_port
    import dtsp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Serial debug pins
    input  wire logic        dev_serial_clock,
    input  wire logic        dev_serial_in,
    output logic             dev_serial_out,
    // Debug module side
    output logic             rx_word_valid,
    output logic [31:0]      rx_word,
    input  wire logic        tx_load,
    input  wire logic [31:0] tx_word,
    // Core trace inputs
    input  wire logic [3:0]  core_status_in,
    input  wire logic [3:0]  capture_in,
    input  wire logic        quiet_clock_bit,
    input  wire logic        trigger_in,
    // Trace pins
    output logic [3:0]       core_status_code,
    output logic [3:0]       debug_capture_bus,
    output logic             status_all_ones,
    output logic             status_strobe_clock,
    output logic             trigger_out
);
    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Both serial pins follow the probe's timing, not ours, so each
    // passes a full chain of flops before any logic may look at it
    localparam int PINS = 2;

    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] pin_sync;
    logic            sclk_prev_q;

    assign pin_raw = {dev_serial_in, dev_serial_clock};

    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_pin_sync
            logic [SYNC_STAGES-1:0] chain_q;

            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    chain_q <= '0;
                else if (clk_en)
                    chain_q <= {chain_q[SYNC_STAGES-2:0], pin_raw[g]};
            end

            // Only the last stage is ever read
            assign pin_sync[g] = chain_q[SYNC_STAGES-1];
        end
    endgenerate

    wire sclk_synced = pin_sync[0];
    wire sin_synced  = pin_sync[1];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sclk_prev_q <= 1'b0;
        else if (clk_en)
            sclk_prev_q <= sclk_synced;
    end

    // Only the rise matters: data is taken and answered on it
    wire sclk_rise = sclk_synced & ~sclk_prev_q;

    ////////////////////////////////////////////////////////////////
    // Status decoding
    // Codes that mark reset exception processing start the strobe
    function automatic logic is_start_code(input logic [3:0] code);
        is_start_code = (code == ST_RESET_C) | (code == ST_RESET_D)
                      | (code == ST_RESET_F);
    endfunction : is_start_code

    ////////////////////////////////////////////////////////////////
    // Serial shift channel
    logic [31:0] rx_shift_q;
    logic [31:0] tx_shift_q;
    logic [5:0]  bit_cnt_q;
    logic        sout_q;
    logic        rx_valid_q;
    logic [31:0] rx_word_q;

    wire         frame_done = (bit_cnt_q == FRAME_LEN - 6'h01) & sclk_rise;
    wire [31:0]  rx_shift_d = {rx_shift_q[30:0], sin_synced};

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_shift_q <= SHIFT_RST;
            tx_shift_q <= SHIFT_RST;
            bit_cnt_q  <= CNT_W0;
            sout_q     <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_word_q  <= SHIFT_RST;
        end
        else if (clk_en)
        begin
            rx_valid_q <= frame_done;
            if (sclk_rise)
            begin
                rx_shift_q <= rx_shift_d;
                tx_shift_q <= {tx_shift_q[30:0], 1'b0};
                sout_q     <= tx_shift_q[31];
                bit_cnt_q  <= frame_done ? CNT_W0 : bit_cnt_q + 6'h01;
            end
            else if (tx_load)
                tx_shift_q <= tx_word;
            if (frame_done)
                rx_word_q <= rx_shift_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Trace outputs and strobe clock
    dtsp_strobe_type strobe_state_q;
    logic [3:0]      status_q;
    logic [3:0]      capture_q;
    logic            all_ones_q;
    logic            strobe_q;
    logic            trig_q;

    wire reset_code   = is_start_code(core_status_in);
    wire trace_live   = (strobe_state_q == STROBE_RUN);
    wire trace_wait   = (strobe_state_q == STROBE_WAIT);
    wire capture_load = trace_live & strobe_q;
    wire trace_load   = trace_wait | capture_load;
    wire all_ones_d   = &core_status_in;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            strobe_state_q <= STROBE_WAIT;
        else if (clk_en)
        begin
            case (strobe_state_q)
                STROBE_WAIT: if (reset_code) strobe_state_q <= STROBE_RUN;
                STROBE_RUN:  if (quiet_clock_bit) strobe_state_q <= STROBE_HOLD;
                STROBE_HOLD: if (!quiet_clock_bit) strobe_state_q <= STROBE_RUN;
                default:     strobe_state_q <= STROBE_WAIT;
            endcase
        end
    end

    // Triggers stay outside the quiet gating on purpose
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            trig_q <= 1'b0;
        else if (clk_en)
            trig_q <= trigger_in;
    end

    // Strobe is clk/2: its rise lands between two data updates,
    // the mid of a 2-cycle window; a faster strobe is not possible
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            strobe_q <= 1'b0;
        else if (clk_en && trace_live)
            strobe_q <= ~strobe_q;
    end

    // Data moves on the edge where the strobe falls; while waiting for a start code, status moves on every edge
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_q   <= ST_IDLE;
            all_ones_q <= 1'b0;
        end
        else if (clk_en && trace_load)
        begin
            status_q   <= core_status_in;
            all_ones_q <= all_ones_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            capture_q <= CAP_IDLE;
        else if (clk_en && capture_load)
            capture_q <= capture_in;
    end

    assign dev_serial_out      = sout_q;
    assign rx_word_valid       = rx_valid_q;
    assign rx_word             = rx_word_q;
    assign core_status_code    = status_q;
    assign debug_capture_bus   = capture_q;
    assign status_all_ones     = all_ones_q;
    assign status_strobe_clock = strobe_q;
    assign trigger_out         = trig_q;
endmodule : dtsp_port
`default_nettype wire

// *** hdl/dtsp_pkg.sv ***
// Constants for the debug trace serial port
package dtsp_pkg;
    localparam logic [3:0] ST_RESET_C = 4'hc;
    localparam logic [3:0] ST_RESET_D = 4'hd;
    localparam logic [3:0] ST_RESET_F = 4'hf;
    localparam logic [3:0] ST_IDLE    = 4'h0;
    localparam logic [3:0] CAP_IDLE   = 4'h0;
    localparam int         SYNC_STAGES = 2;
    localparam int         SHIFT_W     = 32;
    localparam logic [31:0] SHIFT_RST  = 32'h0000_0000;
    localparam logic [5:0]  CNT_W0     = 6'h00;
    localparam logic [5:0]  FRAME_LEN  = 6'h20;

    typedef enum logic [1:0]
    {
        STROBE_WAIT = 2'b00,
        STROBE_RUN  = 2'b01,
        STROBE_HOLD = 2'b10
    } dtsp_strobe_type;
endpackage : dtsp_pkg

// *** tb/dtsp_monitor.sv ***
// Checker bound to the debug trace serial port
`timescale 1ns/10ps
`default_nettype none
module dtsp_monitor
    import dtsp_pkg::*;
(
    // Watched ports
    input wire logic       clk, reset_n, clk_en, quiet_clock_bit, trigger_in, trigger_out,
    input wire logic [3:0] core_status_in, capture_in,
    input wire logic       dev_serial_clock, dev_serial_out, rx_word_valid,
    input wire logic       status_all_ones, status_strobe_clock,
    input wire logic [3:0] core_status_code, debug_capture_bus
);
    logic      seen_q;
    wire logic seen_d = seen_q | (core_status_code inside {ST_RESET_C, ST_RESET_D, ST_RESET_F});
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n) seen_q <= 1'b0;
        else seen_q <= seen_d;
    // Frozen cycles and the first edge after a freeze are skipped
    logic      en_q;
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n) en_q <= 1'b0;
        else en_q <= clk_en;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n || !clk_en || !en_q);
    ////////////////////////////////////////////////////////////////////////////////
    chk_strobe_idle: assert property (!seen_d |-> !status_strobe_clock)
        else $error("strobe early");
    chk_strobe_toggle: assert property (status_strobe_clock && !quiet_clock_bit
        && !$past(quiet_clock_bit) |=> !status_strobe_clock) else $error("strobe stuck");
    // Resume edge excluded, its phase is the design's own
    chk_mid_valid: assert property (status_strobe_clock && seen_q && !$past(quiet_clock_bit)
        |-> $stable(core_status_code) && $stable(debug_capture_bus)) else $error("trace moved");
    chk_quiet_freeze: assert property (quiet_clock_bit [*2] |=> $stable(status_strobe_clock)
        && $stable(core_status_code)) else $error("quiet moved");
    chk_trigger_live: assert property (1'b1 |=> trigger_out == $past(trigger_in))
        else $error("trigger lost");
    chk_all_ones: assert property (status_all_ones == &core_status_code)
        else $error("all ones");
    chk_serial_out: assert property ($changed(dev_serial_out) |-> $past(dev_serial_clock, 2))
        else $error("serial early");
    chk_rx_pulse: assert property (rx_word_valid |=> !rx_word_valid)
        else $error("rx pulse");
    chk_status_follow: assert property (!seen_d |=> core_status_code == $past(core_status_in))
        else $error("status lost");
    chk_capture_load: assert property (status_strobe_clock && seen_q && !quiet_clock_bit
        && !$past(quiet_clock_bit) |=> debug_capture_bus == $past(capture_in)) else $error("capture lost");
    cover property (rx_word_valid);
    cover property (quiet_clock_bit [*2]);
    cover property ($rose(status_strobe_clock));
endmodule : dtsp_monitor
bind dtsp_port dtsp_monitor mon (.clk, .reset_n, .clk_en, .core_status_in, .capture_in,
    .quiet_clock_bit, .trigger_in, .trigger_out,
    .dev_serial_clock, .dev_serial_out, .rx_word_valid, .status_all_ones, .status_strobe_clock,
    .core_status_code, .debug_capture_bus);
`default_nettype wire

// *** tb/dtsp_host.sv ***
// Debug probe model on the serial pins
`timescale 1ns/10ps
`default_nettype none
module dtsp_host
(
    // Serial pins
    output logic      dev_serial_clock, dev_serial_in,
    input  wire logic dev_serial_out
);
    initial {dev_serial_clock, dev_serial_in} = 2'b01;
    // Clock stands low between frames; data idles at its pull-up level
    task automatic frame(input logic [31:0] w, output logic [31:0] r);
        #3;
        for (int i = 31; i >= 0; i--)
        begin
            dev_serial_in = w[i];
            #40 dev_serial_clock = 1'b1;
            #40 dev_serial_clock = 1'b0;
            r[i] = dev_serial_out;
        end
        dev_serial_in = 1'b1;
    endtask : frame
endmodule : dtsp_host
`default_nettype wire

// *** tb/dtsp_port_bench.sv ***
// Self-checking bench for the debug trace serial port
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) checks++; if ((s) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end
module dtsp_port_bench;
    import dtsp_pkg::*;
    logic        clk, reset_n, clk_en, tx_load, quiet_clock_bit, trigger_in, dev_serial_clock;
    logic [8:0]  snap;
    logic        dev_serial_in, dev_serial_out, rx_word_valid, status_all_ones;
    logic        status_strobe_clock, trigger_out;
    logic [3:0]  core_status_in, capture_in, core_status_code, debug_capture_bus;
    logic [31:0] tx_word, rx_word, got, eq, w, x;
    logic [31:0] expq[$];
    int          mismatches, checks, seed = 74;
    dtsp_port dut (.clk, .reset_n, .clk_en, .dev_serial_clock, .dev_serial_in,
        .dev_serial_out, .rx_word_valid, .rx_word, .tx_load, .tx_word, .core_status_in,
        .capture_in, .quiet_clock_bit, .trigger_in, .core_status_code, .debug_capture_bus,
        .status_all_ones, .status_strobe_clock, .trigger_out);
    dtsp_host host (.dev_serial_clock, .dev_serial_in, .dev_serial_out);
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic report_and_stop;
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {reset_n, tx_load, quiet_clock_bit, trigger_in} = 4'h0;
        clk_en = 1'b1;
        {tx_word, core_status_in, capture_in} = '0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        // Low codes first keep the strobe idle; quiet window once it runs
        for (int i = 0; i < 120; i++)
        begin
            @(posedge clk);
            w = $random(seed);
            core_status_in <= (i < 20) ? {1'b0, w[2:0]} : (i == 20) ? ST_RESET_D : w[3:0];
            capture_in <= w[7:4];
            trigger_in <= w[8];
            quiet_clock_bit <= (i > 60 && i < 80);
            // Short freeze while the strobe runs: nothing may move
            clk_en <= (i < 40 || i >= 44);
            if (i == 41) snap = {core_status_code, debug_capture_bus, status_strobe_clock};
            if (i == 44)
            begin
                `CHK("frozen", snap, {core_status_code, debug_capture_bus, status_strobe_clock})
            end
        end
        for (int f = 0; f < 3; f++)
        begin
            @(posedge clk);
            w = $random(seed);
            tx_load <= 1'b1;
            tx_word <= w;
            @(posedge clk);
            tx_load <= 1'b0;
            x = $random(seed);
            expq.push_back(x);
            host.frame(x, got);
            `CHK("serial out", w, got)
        end
        repeat (10) @(posedge clk);
        report_and_stop();
    end
    always @(negedge clk)
        if (rx_word_valid === 1'b1)
        begin
            eq = expq.pop_front();
            `CHK("rx word", eq, rx_word)
        end
    // Whole run needs about 9 us
    initial
    begin
        #20000;
        mismatches++;
        report_and_stop();
    end
endmodule : dtsp_port_bench
`default_nettype wire
